// [refresh_pkg.sv]
// Shared constants for the display refresh link: bus widths, port addresses,
// position codes, timing counts, host register map and state encodings.
// Assumes one 250 MHz clock shared by both ends.
package refresh_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int IRQ_HZ = 1600;
    localparam int IRQ_PERIOD_CYC = CLK_HZ / IRQ_HZ;
    localparam int DIV_W = 18;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int GLYPH_W = 6;
    localparam int POS_W = 5;
    localparam int NUM_POS = 16;
    localparam int SEG_W = 18;
    localparam int FONT_N = 64;

    localparam logic [ADDR_W-1:0] GLYPH_PORT_ADDR = 16'h0040;
    localparam logic [ADDR_W-1:0] COLUMN_PORT_ADDR = 16'h0041;

    localparam logic [POS_W-1:0] POS_FIRST = 5'h00;
    localparam logic [POS_W-1:0] POS_LAST = 5'h0f;
    localparam logic [POS_W-1:0] POS_OFF = 5'h1f;
    localparam logic [GLYPH_W-1:0] GLYPH_RESET = 6'h20;
    localparam logic [GLYPH_W-1:0] GLYPH_BASE = 6'h20;

    // Wait cycles the device inserts on every selected access
    localparam int WAIT_W = 2;
    localparam logic [WAIT_W-1:0] DEV_WAIT_CYC = 2'h1;

    // Dark time between loading a glyph and enabling its column
    localparam int GHOST_DELAY_NS = 1000;
    localparam int GHOST_DELAY_CYC = GHOST_DELAY_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int DLY_W = 8;

    // Status word sent ahead of every bus cycle
    localparam int STS_W = 2;
    localparam int STS_IO_BIT = 0;
    localparam int STS_WR_BIT = 1;
    localparam logic HOST_USES_IO = 1'b1;

    // Host software registers
    localparam int SW_ADDR_W = 5;
    localparam logic [SW_ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [SW_ADDR_W-1:0] REG_STATUS = 5'h01;
    localparam logic [SW_ADDR_W-1:0] REG_MASK = 5'h02;
    localparam logic [SW_ADDR_W-1:0] REG_SCAN = 5'h03;
    localparam logic [SW_ADDR_W-1:0] REG_ECHO = 5'h04;
    localparam int BUF_SEL_BIT = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam int EV_W = 2;
    localparam int EV_SERVICED = 0;
    localparam int EV_WRAP = 1;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_OFF_A = 4'b0001,
        H_OFF_S = 4'b0010,
        H_GLY_A = 4'b0011,
        H_GLY_S = 4'b0100,
        H_DELAY = 4'b0101,
        H_POS_A = 4'b0110,
        H_POS_S = 4'b0111,
        H_RD_A = 4'b1000,
        H_RD_S = 4'b1001
    } host_state_t;
endpackage

// [display_bus_if.sv]
// Parallel host bus between the refresh host and the display refresh device.
// The shared data wire is resolved here from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface display_bus_if;
    logic [refresh_pkg::ADDR_W-1:0] addr;
    logic [refresh_pkg::DATA_W-1:0] host_dout;
    logic host_oe;
    logic [refresh_pkg::DATA_W-1:0] dev_dout;
    logic dev_oe;
    logic [refresh_pkg::DATA_W-1:0] data;
    logic wr;
    logic rd;
    logic valid;
    logic sync;
    logic [refresh_pkg::STS_W-1:0] status;
    logic ready;
    logic irq;

    // Floating bus reads as all ones
    assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hff);

    modport dev(input addr, data, wr, rd, valid, sync, status,
                output dev_dout, dev_oe, ready, irq);
    modport host(input data, ready, irq,
                 output addr, host_dout, host_oe, wr, rd, valid, sync, status);
endinterface
`default_nettype wire

// [bus_status_decoder.sv]
// Latches the status word marked by sync and turns it, with the strobes and
// the valid-address qualifier, into memory/I-O read and write strobes.
// Assumes the status word is presented in the cycle before the strobe.
`timescale 1ns/1ps
`default_nettype none
module bus_status_decoder (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sync,
    input wire logic [refresh_pkg::STS_W-1:0] i_status,
    input wire logic i_valid,
    input wire logic i_rd,
    input wire logic i_wr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic o_io_rd,
    output logic o_io_wr
);
    import refresh_pkg::*;

    typedef struct packed {
        logic [STS_W-1:0] word;
    } dec_state_t;

    dec_state_t s;
    dec_state_t next_s;
    logic is_io;

    always_comb begin
        next_s = s;
        if (i_sync) begin
            next_s.word = i_status; // [R15]
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign is_io = s.word[STS_IO_BIT];
    // Qualifier must accompany every strobe [R13]
    assign o_mem_rd = i_valid & i_rd & ~is_io; // [R16]
    assign o_mem_wr = i_valid & i_wr & ~is_io; // [R16]
    assign o_io_rd = i_valid & i_rd & is_io; // [R16]
    assign o_io_wr = i_valid & i_wr & is_io; // [R16]
endmodule
`default_nettype wire

// [display_refresh_dev.sv]
// Display refresh device: periodic interrupt, glyph and column ports,
// segment font lookup and column enable decode for sixteen positions.
// Assumes the host holds each strobe until it samples ready high.
`timescale 1ns/1ps
`default_nettype none
module display_refresh_dev #(
    parameter int IRQ_PERIOD = refresh_pkg::IRQ_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    display_bus_if.dev bus,
    output logic [refresh_pkg::SEG_W-1:0] o_segments,
    output logic [refresh_pkg::NUM_POS-1:0] o_digit_en
);
    import refresh_pkg::*;

    // Segment patterns, last entry is index 0 (code 20 hex, space)
    localparam logic [FONT_N-1:0][SEG_W-1:0] FONT = {
        18'h00008, 18'h00c21, 18'h2a500, 18'h0031e, 18'h11420, 18'h003e0, 18'h3c00c, 18'h0210e,
        18'h1c081, 18'h011e6, 18'h3c0f1, 18'h3c0ed, 18'h0c381, 18'h01c0f, 18'h0c1af, 18'h0c3f3,
        18'h0c0ff, 18'h0d0ff, 18'h04387, 18'h2e4e0, 18'h081ee, 18'h000c0, 18'h24066, 18'h02d06,
        18'h0903e, 18'h0c0e7, 18'h0c0f3, 18'h00c1f, 18'h0c1fe, 18'h0c0ff, 18'h0c187, 18'h0c0ff,
        18'h04883, 18'h00008, 18'h000c8, 18'h24000, 18'h00800, 18'h20800, 18'h10000, 18'h20000,
        18'h0c0ff, 18'h0c0ef, 18'h0003f, 18'h0c0fd, 18'h0c0cc, 18'h0c0bd, 18'h0c0ed, 18'h0c0ef,
        18'h00c00, 18'h00000, 18'h0c000, 18'h0c000, 18'h12000, 18'h2c000, 18'h0000c, 18'h0c0e1,
        18'h0c020, 18'h22000, 18'h0c18a, 18'h0c0e9, 18'h0c0c3, 18'h00204, 18'h00006, 18'h00000
    };

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic irq;
        logic [GLYPH_W-1:0] glyph;
        logic [POS_W-1:0] column;
        logic [WAIT_W-1:0] wait_cnt;
        logic [DATA_W-1:0] rd_data;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic hit_glyph;
    logic hit_column;
    logic sel_rd;
    logic sel_wr;
    logic ready;
    logic tick;

    bus_status_decoder bus_status_decoder_inst (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_sync(bus.sync),
        .i_status(bus.status),
        .i_valid(bus.valid),
        .i_rd(bus.rd),
        .i_wr(bus.wr),
        .o_mem_rd(mem_rd),
        .o_mem_wr(mem_wr),
        .o_io_rd(io_rd),
        .o_io_wr(io_wr)
    );

    // Address alone picks the port; memory or I-O space both reach it [R12]
    assign hit_glyph = (bus.addr == GLYPH_PORT_ADDR);
    assign hit_column = (bus.addr == COLUMN_PORT_ADDR);
    assign sel_rd = (mem_rd | io_rd) & (hit_glyph | hit_column);
    assign sel_wr = (mem_wr | io_wr) & (hit_glyph | hit_column);
    // Slow target: holds ready low for the first wait cycles [R17]
    assign ready = ~(sel_rd | sel_wr) | (s.wait_cnt == DEV_WAIT_CYC);
    assign tick = (s.div == DIV_W'(IRQ_PERIOD - 1));

    always_comb begin
        next_s = s;
        next_s.div = tick ? '0 : s.div + 1'b1; // [R1]
        next_s.wait_cnt = '0;
        if ((sel_rd | sel_wr) & ~ready) begin
            next_s.wait_cnt = s.wait_cnt + 1'b1; // [R17]
        end
        next_s.rd_data = hit_glyph ? DATA_W'(s.glyph) : DATA_W'(s.column);
        if (sel_wr & ready) begin
            if (hit_glyph) begin
                next_s.glyph = bus.data[GLYPH_W-1:0]; // [R5] [R11]
                next_s.irq = 1'b0;
            end else begin
                next_s.column = bus.data[POS_W-1:0]; // [R6] [R11]
            end
        end
        // A new period wins over the acknowledge in the same cycle
        if (tick) begin
            next_s.irq = 1'b1; // [R1]
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s.div <= '0;
            s.irq <= 1'b0;
            s.glyph <= GLYPH_RESET;
            s.column <= POS_OFF;
            s.wait_cnt <= '0;
            s.rd_data <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.irq = s.irq;
    assign bus.ready = ready;
    assign bus.dev_dout = s.rd_data;
    assign bus.dev_oe = sel_rd; // [R10]

    assign o_segments = FONT[s.glyph ^ GLYPH_BASE]; // [R9]

    // One column per position word 00..0F; any other word, 1F included, is dark
    always_comb begin
        o_digit_en = '0;
        for (int i = 0; i < NUM_POS; i++) begin
            if (s.column == POS_W'(i)) begin
                o_digit_en[i] = 1'b1; // [R3] [R4]
            end
        end
    end
endmodule
`default_nettype wire

// [display_refresh_host.sv]
// Refresh host: on each device interrupt writes the dark column word, the
// next glyph, waits, then the next column word, from a 16-byte message.
// It then reads the column word back into a software register.
// Software drives it through a small register port with read data one
// cycle after the read strobe. Assumes the device answers with ready.
//
// Behaviour
// R1 - Device interrupts at 1600 Hz, per position
// R2 - Host sends glyph and column per interrupt
// R3 - Column word 00 leftmost, 0F rightmost
// R4 - Column word 1F darkens every position
// R5 - Glyph port write stores six-bit code
// R6 - Column port write stores five-bit word
// R7 - Dark column, then glyph, delay, column
// R8 - Host keeps cursor and scan index
// R9 - Font maps codes 20 to 5F
// R10 - Only selected element drives read data
// R11 - Address first, then strobe with data
// R12 - Address decode alone selects shared space
// R13 - Access valid only with address qualifier
// R14 - Data gate drives host data outward
// R15 - Status word latched on sync marker
// R16 - Status and strobes give four strobes
// R17 - Target stretches access with ready low
// R18 - Rightmost done: rewind cursor and index
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module display_refresh_host (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    display_bus_if.host bus,
    input wire logic [refresh_pkg::SW_ADDR_W-1:0] i_addr,
    input wire logic [refresh_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [refresh_pkg::DATA_W-1:0] o_rdata,
    output logic o_irq
);
    import refresh_pkg::*;

    typedef struct packed {
        host_state_t state;
        logic enable;
        logic [EV_W-1:0] events;
        logic [EV_W-1:0] mask;
        logic [NUM_POS-1:0][DATA_W-1:0] message;
        logic [3:0] cursor;
        logic [POS_W-1:0] scan;
        logic [DLY_W-1:0] delay;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] rdata;
        logic [POS_W-1:0] echo;
    } host_regs_t;

    host_regs_t s;
    host_regs_t next_s;
    logic strobe_phase;
    logic addr_phase;
    logic wrapped;
    logic reading;

    assign wrapped = (s.scan == POS_LAST);
    assign reading = (s.state == H_RD_A) | (s.state == H_RD_S);

    always_comb begin
        next_s = s;

        // Software register port
        next_s.rdata = '0;
        if (i_rd) begin
            if (i_addr[BUF_SEL_BIT]) begin
                next_s.rdata = s.message[i_addr[3:0]];
            end else begin
                case (i_addr)
                    REG_CTRL: next_s.rdata = DATA_W'(s.enable);
                    REG_STATUS: next_s.rdata = DATA_W'(s.events);
                    REG_MASK: next_s.rdata = DATA_W'(s.mask);
                    REG_SCAN: next_s.rdata = DATA_W'(s.scan);
                    REG_ECHO: next_s.rdata = DATA_W'(s.echo);
                    default: next_s.rdata = '0;
                endcase
            end
        end
        if (i_wr) begin
            if (i_addr[BUF_SEL_BIT]) begin
                next_s.message[i_addr[3:0]] = i_wdata;
            end else begin
                case (i_addr)
                    REG_CTRL: next_s.enable = i_wdata[CTRL_EN_BIT];
                    REG_STATUS: next_s.events = s.events & ~i_wdata[EV_W-1:0];
                    REG_MASK: next_s.mask = i_wdata[EV_W-1:0];
                    default: next_s.enable = s.enable;
                endcase
            end
        end

        // Refresh sequence; events set after the clear so they win
        case (s.state)
            H_IDLE: begin
                if (s.enable & bus.irq) begin
                    next_s.state = H_OFF_A; // [R2]
                    next_s.addr = COLUMN_PORT_ADDR;
                    next_s.dout = DATA_W'(POS_OFF); // [R7]
                end
            end
            H_OFF_A: begin
                next_s.state = H_OFF_S; // [R11]
            end
            H_OFF_S: begin
                if (bus.ready) begin
                    next_s.state = H_GLY_A; // [R17]
                    next_s.addr = GLYPH_PORT_ADDR;
                    next_s.dout = s.message[s.cursor]; // [R7] [R8]
                end
            end
            H_GLY_A: begin
                next_s.state = H_GLY_S; // [R11]
            end
            H_GLY_S: begin
                if (bus.ready) begin
                    next_s.state = H_DELAY;
                    next_s.delay = '0;
                end
            end
            H_DELAY: begin
                next_s.delay = s.delay + 1'b1;
                if (s.delay == DLY_W'(GHOST_DELAY_CYC - 1)) begin
                    next_s.state = H_POS_A; // [R7]
                    next_s.addr = COLUMN_PORT_ADDR;
                    next_s.dout = DATA_W'(s.scan);
                end
            end
            H_POS_A: begin
                next_s.state = H_POS_S; // [R11]
            end
            H_POS_S: begin
                if (bus.ready) begin
                    next_s.state = H_RD_A;
                    next_s.events[EV_SERVICED] = 1'b1;
                    if (wrapped) begin
                        next_s.scan = POS_FIRST; // [R18]
                        next_s.cursor = '0; // [R18]
                        next_s.events[EV_WRAP] = 1'b1;
                    end else begin
                        next_s.scan = s.scan + 1'b1; // [R8]
                        next_s.cursor = s.cursor + 1'b1; // [R8]
                    end
                end
            end
            // Read the column word back so a stuck latch shows in software
            H_RD_A: begin
                next_s.state = H_RD_S; // [R10]
            end
            H_RD_S: begin
                if (bus.ready) begin
                    next_s.state = H_IDLE; // [R17]
                    next_s.echo = bus.data[POS_W-1:0]; // [R10]
                end
            end
            default: begin
                next_s.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s.state <= H_IDLE;
            s.enable <= 1'b0;
            s.events <= '0;
            s.mask <= '0;
            s.message <= '0;
            s.cursor <= '0;
            s.scan <= POS_FIRST;
            s.delay <= '0;
            s.addr <= '0;
            s.dout <= '0;
            s.rdata <= '0;
            s.echo <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign addr_phase = (s.state == H_OFF_A) | (s.state == H_GLY_A) | (s.state == H_POS_A)
        | (s.state == H_RD_A);
    assign strobe_phase = (s.state == H_OFF_S) | (s.state == H_GLY_S) | (s.state == H_POS_S)
        | (s.state == H_RD_S);

    // Address leads the strobe by one cycle and stays through it
    assign bus.addr = s.addr; // [R11]
    assign bus.host_dout = s.dout;
    assign bus.host_oe = strobe_phase & ~reading; // [R14]
    assign bus.wr = strobe_phase & ~reading; // [R11]
    assign bus.rd = strobe_phase & reading; // [R10]
    assign bus.valid = strobe_phase; // [R13]
    assign bus.sync = addr_phase; // [R15]
    always_comb begin
        bus.status = '0;
        bus.status[STS_WR_BIT] = ~reading; // [R16]
        bus.status[STS_IO_BIT] = HOST_USES_IO; // [R12]
    end

    assign o_rdata = s.rdata;
    assign o_irq = |(s.events & s.mask);
endmodule
`default_nettype wire

// [display_refresh_monitor.sv]
// Checker for the host bus joining the refresh host and display device.
// Assumes one clock domain and the interface signals wired in by name.
`timescale 1ns/1ps
`default_nettype none
module display_refresh_monitor #(
    parameter int IRQ_PERIOD = refresh_pkg::IRQ_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [refresh_pkg::ADDR_W-1:0] addr,
    input wire logic [refresh_pkg::DATA_W-1:0] data,
    input wire logic wr,
    input wire logic rd,
    input wire logic valid,
    input wire logic sync,
    input wire logic [refresh_pkg::STS_W-1:0] status,
    input wire logic ready,
    input wire logic irq,
    input wire logic dev_oe,
    input wire logic host_oe
);
    import refresh_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic cap_gly, cap_col, irq_q, rise_seen;
    logic [POS_W-1:0] last_col;
    int rise_gap, ghost_gap;
    assign cap_gly = wr && valid && ready && addr == GLYPH_PORT_ADDR;
    assign cap_col = wr && valid && ready && addr == COLUMN_PORT_ADDR;

    // Cycles since the last interrupt rise and since the last glyph load
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_q <= 1'b0;
            rise_seen <= 1'b0;
            rise_gap <= 0;
            ghost_gap <= 0;
            last_col <= POS_OFF;
        end else begin
            irq_q <= irq;
            rise_seen <= rise_seen || (irq && !irq_q);
            rise_gap <= (irq && !irq_q) ? 0 : rise_gap + 1;
            ghost_gap <= cap_gly ? 0 : (ghost_gap < 1000 ? ghost_gap + 1 : ghost_gap);
            last_col <= cap_col ? data[POS_W-1:0] : last_col;
        end
    end

    a_irq_period: assert property (
        irq && !irq_q && rise_seen |-> rise_gap % IRQ_PERIOD == IRQ_PERIOD - 1)
        else $error("interrupt spacing off");
    a_irq_ack: assert property (cap_gly |=> !irq)
        else $error("interrupt not cleared by glyph load");
    a_dark_first: assert property (cap_gly |-> last_col == POS_OFF)
        else $error("glyph loaded while a column lit");
    a_ghost_delay: assert property (
        cap_col && data[POS_W-1:0] != POS_OFF |-> ghost_gap >= GHOST_DELAY_CYC)
        else $error("column lit too soon after glyph");
    a_one_wait: assert property ($rose(valid) |-> !ready ##1 (ready && valid))
        else $error("wait cycle count wrong");
    a_status_first: assert property (
        $rose(wr) |-> $past(sync) && $past(status[STS_WR_BIT]) && $past(status[STS_IO_BIT]))
        else $error("status word missing before write");
    a_hold_request: assert property (
        wr && !ready |=> wr && valid && $stable(addr) && $stable(data))
        else $error("request changed before ready");
    a_write_drive: assert property (wr |-> valid && host_oe && !dev_oe)
        else $error("write without qualifier or data driver");
    a_read_drive: assert property (rd |-> valid && !wr && !host_oe)
        else $error("read with write or host data driver");
    a_read_data: assert property (rd && ready |-> dev_oe && data == DATA_W'(last_col))
        else $error("readback differs from column word");
    a_idle_float: assert property (!(rd && valid) |-> !dev_oe)
        else $error("device drives bus unselected");

    cover property (cap_gly);
    cover property (cap_col && data[POS_W-1:0] == POS_LAST);
    cover property (irq && !irq_q && rise_seen);
    cover property (rd && valid && ready && dev_oe);
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench for the refresh host and display device joined by their bus.
// Assumes a shortened interrupt period; drives the host register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import refresh_pkg::*;
    localparam int PERIOD = 400;
    logic i_clk, i_sys_rst, i_wr, i_rd, o_irq, dark;
    logic [SW_ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, rv;
    logic [SEG_W-1:0] o_segments;
    logic [SEG_W-1:0] seen_seg [NUM_POS];
    logic [NUM_POS-1:0] o_digit_en;
    int fails, compares;

    display_bus_if bus ();
    display_refresh_dev #(.IRQ_PERIOD(PERIOD)) display_refresh_dev_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .bus(bus), .o_segments(o_segments), .o_digit_en(o_digit_en));
    display_refresh_host display_refresh_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .bus(bus), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq));
    display_refresh_monitor #(.IRQ_PERIOD(PERIOD)) display_refresh_monitor_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .addr(bus.addr), .data(bus.data),
        .wr(bus.wr), .rd(bus.rd), .valid(bus.valid), .sync(bus.sync), .status(bus.status),
        .ready(bus.ready), .irq(bus.irq), .dev_oe(bus.dev_oe), .host_oe(bus.host_oe));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic sw_write(input logic [SW_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [SW_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Waits for one lit column, noting whether all columns went dark first
    task automatic wait_digit(input logic [NUM_POS-1:0] want);
        int n;
        dark = 1'b0;
        for (n = 0; n < 2000 && o_digit_en !== want; n++) begin
            @(posedge i_clk);
            #1;
            if (o_digit_en === '0) dark = 1'b1;
        end
        if (o_digit_en !== want) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic t_reset_regs();
        int k;
        `CHK("dark columns", 16'h0000, o_digit_en)
        `CHK("blank glyph", 18'h00000, o_segments)
        for (k = 0; k < 4; k++) begin
            sw_read(k[SW_ADDR_W-1:0], rv);
            `CHK("reset register", 8'h00, rv)
        end
        sw_write(5'h05, 8'hff);
        sw_read(5'h05, rv);
        `CHK("unmapped", 8'h00, rv)
        sw_write(REG_MASK, 8'h03);
        sw_read(REG_MASK, rv);
        `CHK("mask", 8'h03, rv)
        sw_write(REG_MASK, 8'h00);
    endtask

    task automatic t_refresh();
        int p;
        for (p = 0; p < NUM_POS; p++) begin
            sw_write(5'h10 + p[SW_ADDR_W-1:0], 8'h20 + 8'(4 * (p % 8)));
        end
        sw_write(REG_CTRL, 8'h01);
        for (p = 0; p < NUM_POS; p++) begin
            wait_digit(16'h0001 << p);
            `CHK("column", 16'h0001 << p, o_digit_en)
            `CHK("dark gap", 1'b1, dark)
            seen_seg[p] = o_segments;
            if (p >= 8) `CHK("glyph", seen_seg[p-8], o_segments)
            sw_read(REG_SCAN, rv);
            `CHK("scan", 8'((p + 1) % NUM_POS), rv)
            sw_read(REG_ECHO, rv);
            `CHK("column echo", 8'(p), rv)
        end
        `CHK("space glyph", 18'h00000, seen_seg[0])
        `CHK("glyph differs", 1'b0, seen_seg[1] == seen_seg[0])
        `CHK("irq masked", 1'b0, o_irq)
    endtask

    task automatic t_irq();
        sw_read(REG_STATUS, rv);
        `CHK("events", 8'h03, rv)
        sw_write(REG_CTRL, 8'h00);
        repeat (PERIOD) @(posedge i_clk);
        sw_write(REG_MASK, 8'h02);
        repeat (2) @(posedge i_clk);
        #1 `CHK("irq wrap", 1'b1, o_irq)
        sw_write(REG_STATUS, 8'h02);
        sw_read(REG_STATUS, rv);
        `CHK("partial clear", 8'h01, rv)
        `CHK("irq cleared", 1'b0, o_irq)
        sw_write(REG_MASK, 8'h01);
        repeat (2) @(posedge i_clk);
        #1 `CHK("irq serviced", 1'b1, o_irq)
        sw_write(REG_STATUS, 8'h01);
        sw_read(REG_STATUS, rv);
        `CHK("full clear", 8'h00, rv)
        `CHK("irq low", 1'b0, o_irq)
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    initial begin
        i_sys_rst = 1'b1;
        i_addr = '0;
        i_wdata = '0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reset_regs();
        t_refresh();
        t_irq();
        end_sim();
    end
endmodule
`default_nettype wire
